/* File: adc_model.sv */
`timescale 1ns/1ps

// =====
// behavioural converter on the far side of the sequencer
// =====
module adc_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        adc_start,
	input  wire logic [3:0]  delay,
	input  wire logic [23:0] temp_in,
	input  wire logic [23:0] press_in,
	output logic             adc_done,
	output logic [23:0]      adc_temp,
	output logic [23:0]      adc_press
);
	logic [3:0] cnt;  // cycles left in conversion
	logic       busy; // conversion in flight

	// conversion timer, delay picked by the bench for fast or slow answers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy     <= 1'b0;
			cnt      <= 4'h0;
			adc_done <= 1'b0;
		end else begin
			adc_done <= 1'b0;
			if (adc_start) begin
				busy <= 1'b1;
				cnt  <= delay;
			end else if (busy && cnt == 4'h0) begin
				busy     <= 1'b0;
				adc_done <= 1'b1;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end

	// data only valid with done; inverted otherwise so stale values never match
	assign adc_temp  = adc_done ? temp_in : ~temp_in;
	assign adc_press = adc_done ? press_in : ~press_in;
endmodule : adc_model

/* File: interval_timer.sv */
`timescale 1ns/1ps

// ==========================================================
// down counter for the standby period
// ==========================================================
module interval_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        load,
	input  wire logic [31:0] load_value,
	output logic             expired,
	output logic             busy
);

	// remaining cycles
	logic [31:0] remain;

	// ==========================================================
	// count down, one-cycle expiry pulse at the end
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			remain  <= 32'h0;
			busy    <= 1'b0;
			expired <= 1'b0;
		end else if (clk_en) begin
			expired <= 1'b0;
			if (load) begin
				// zero load still waits one cycle
				remain <= (load_value == 32'h0) ? 32'h1 : load_value;
				busy   <= 1'b1;
			end else if (busy) begin
				if (remain == 32'h1) begin
					busy    <= 1'b0;
					expired <= 1'b1;
				end
				remain <= remain - 32'h1;
			end
		end
	end

endmodule : interval_timer

/* File: pressure_sensor_mode_and_comp.sv */
`timescale 1ns/1ps
`include "sensor_defs.svh"

// Functional notes
// [RQ1] i2c address 70h strap low, 56h high
// [RQ2] spi three-wire when select 1, else four-wire
// [RQ3] chip select high keeps i2c slave
// [RQ4] chip select low switches to spi
// [RQ5] spi mode sticks until reset
// [RQ6] reset starts in i2c mode
// [RQ7] three power modes chosen by register write
// [RQ8] sleep does no measurement, registers stay usable
// [RQ9] forced: one measurement, store, back to sleep
// [RQ10] normal: measure, standby by 3-bit field, repeat
// [RQ11] host order: setup, coefficients, mode, temp, pressure
// [RQ12] host temperature polynomial, divide by 256
// [RQ13] raw readings 20-24 bits over byte registers
// [RQ14] host pressure polynomial from raw pressure
// [RQ15] host coefficient A plus S word over 32767
// [RQ16] host offset coefficients from three registers, /16
// [RQ17] host treats coefficient words as signed
module pressure_sensor_mode_and_comp
#(
	parameter int STANDBY_UNIT_CYCLES = `STANDBY_UNIT_CYCLES
) (
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	input  wire logic                          clk_en,
	input  wire logic                          mode_strap_chip_select,
	input  wire logic                          addr_strap,
	input  wire logic                          link_clk,
	input  wire logic                          three_wire_select,
	input  wire logic                          power_mode_wr,
	input  sensor_pkg::power_mode_t            power_mode_req,
	input  wire logic [`STANDBY_SEL_WIDTH-1:0] standby_sel,
	input  wire logic                          adc_done,
	input  wire logic [`RAW_WIDTH-1:0]         adc_temp,
	input  wire logic [`RAW_WIDTH-1:0]         adc_press,
	input  wire logic                          data_read,
	output logic                               spi_mode,
	output logic                               i2c_mode,
	output logic [`SLAVE_ADDR_WIDTH-1:0]       slave_addr,
	output logic                               three_wire_active,
	output logic                               four_wire_active,
	output sensor_pkg::power_mode_t            power_mode,
	output logic                               measuring,
	output logic                               adc_start,
	output logic [`RAW_WIDTH-1:0]              temp_raw_regs,
	output logic [`RAW_WIDTH-1:0]              pressure_raw_regs,
	output logic                               data_ready,
	output logic                               link_clk_rise
);
	import sensor_pkg::*;

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic        cs_s1;       // first stage, read only by cs_s2
	logic        cs_s2;       // chip select, safe to use
	logic        addr_s1;     // first stage
	logic        addr_s2;     // address strap, safe to use
	logic        lclk_s1;     // first stage
	logic        lclk_s2;     // link clock level
	logic        lclk_prev;   // last link clock level for edges

	// sequencer
	meas_state_t state;       // current sequencer state
	logic        timer_load;  // starts the standby count
	logic        timer_expired;
	logic        timer_busy;
	logic [31:0] standby_cycles;
	logic        forced_now;  // forced mode in either encoding
	logic        meas_end;    // measurement finishes this cycle

	// ==========================================================
	// two flip-flops on chip select, address strap and link clock before any logic
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			addr_s1 <= 1'b0;
			addr_s2 <= 1'b0;
			lclk_s1 <= 1'b0;
			lclk_s2 <= 1'b0;
		end else if (clk_en) begin
			cs_s1   <= mode_strap_chip_select;
			cs_s2   <= cs_s1;
			addr_s1 <= addr_strap;
			addr_s2 <= addr_s1;
			lclk_s1 <= link_clk;
			lclk_s2 <= lclk_s1;
		end
	end

	// ==========================================================
	// link clock edge finder, drives the link_clk_rise output
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lclk_prev     <= 1'b0;
			link_clk_rise <= 1'b0;
		end else if (clk_en) begin
			lclk_prev     <= lclk_s2;
			// only the synchronised copy is compared
			link_clk_rise <= lclk_s2 & ~lclk_prev;
		end
	end

	// ==========================================================
	// interface mode latch
	// ==========================================================
	// a low chip select is one-way: only reset returns to i2c
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			spi_mode <= `RESET_SPI_MODE; // RQ6
			i2c_mode <= ~`RESET_SPI_MODE; // RQ6
		end else if (clk_en) begin
			if (!cs_s2) begin
				spi_mode <= 1'b1; // RQ4
				i2c_mode <= 1'b0; // RQ4
			end else begin
				// high chip select never leaves spi again
				spi_mode <= spi_mode; // RQ5
				i2c_mode <= ~spi_mode; // RQ3
			end
		end
	end

	// ==========================================================
	// i2c slave address from the strap
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			slave_addr <= `ADDR_STRAP_LOW_SLAVE;
		end else if (clk_en) begin
			// strap is re-read every cycle, no latching at reset
			slave_addr <= addr_s2 ? `ADDR_STRAP_HIGH_SLAVE
			                      : `ADDR_STRAP_LOW_SLAVE; // RQ1
		end
	end

	// ==========================================================
	// spi wiring choice
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			three_wire_active <= 1'b0;
			four_wire_active  <= 1'b0;
		end else if (clk_en) begin
			// both low while still in i2c
			three_wire_active <= spi_mode & three_wire_select; // RQ2
			four_wire_active  <= spi_mode & ~three_wire_select; // RQ2
		end
	end

	// ==========================================================
	// power mode field
	// ==========================================================
	assign forced_now = (power_mode == PMODE_FORCED) || (power_mode == PMODE_FORCED_ALT);
	assign meas_end   = (state == ST_MEASURE) && adc_done;

	// a host write in the same cycle as the forced end wins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_mode <= PMODE_SLEEP;
		end else if (clk_en) begin
			if (power_mode_wr) begin
				power_mode <= power_mode_req; // RQ7
			end else if (meas_end && forced_now) begin
				power_mode <= PMODE_SLEEP; // RQ9
			end
		end
	end

	// ==========================================================
	// standby length: unit doubled per step of the field
	// ==========================================================
	assign standby_cycles = 32'(STANDBY_UNIT_CYCLES) << standby_sel; // RQ10

	// ==========================================================
	// measurement sequencer
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state      <= ST_IDLE;
			adc_start  <= 1'b0;
			measuring  <= 1'b0;
			timer_load <= 1'b0;
		end else if (clk_en) begin
			adc_start  <= 1'b0;
			timer_load <= 1'b0;
			case (state)
				ST_IDLE: begin
					// sleep leaves the converter alone
					if (power_mode != PMODE_SLEEP) begin // RQ8
						state     <= ST_MEASURE;
						adc_start <= 1'b1;
						measuring <= 1'b1;
					end
				end
				ST_MEASURE: begin
					// a started conversion always runs to its end
					if (adc_done) begin
						measuring <= 1'b0;
						if (power_mode == PMODE_NORMAL) begin
							state      <= ST_STANDBY; // RQ10
							timer_load <= 1'b1;
						end else begin
							state <= ST_IDLE; // RQ9
						end
					end
				end
				ST_STANDBY: begin
					if (power_mode != PMODE_NORMAL) begin
						state <= ST_IDLE;
					end else if (timer_expired) begin
						state     <= ST_MEASURE; // RQ10
						adc_start <= 1'b1;
						measuring <= 1'b1;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// standby counter
	interval_timer u_standby (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.clk_en     (clk_en),
		.load       (timer_load),
		.load_value (standby_cycles),
		.expired    (timer_expired),
		.busy       (timer_busy)
	);

	// ==========================================================
	// raw result byte registers, one per byte lane
	// ==========================================================
	generate
		for (genvar gi = 0; gi < `RAW_BYTES; gi++) begin : g_raw_byte
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					temp_raw_regs[gi*8 +: 8]     <= `RESET_RAW_BYTE;
					pressure_raw_regs[gi*8 +: 8] <= `RESET_RAW_BYTE;
				end else if (clk_en && meas_end) begin
					// both readings land together, never half old
					temp_raw_regs[gi*8 +: 8]     <= adc_temp[gi*8 +: 8]; // RQ13
					pressure_raw_regs[gi*8 +: 8] <= adc_press[gi*8 +: 8]; // RQ13
				end
			end
		end
	endgenerate

	// ==========================================================
	// new data flag, set wins over the host read
	// ==========================================================
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			data_ready <= 1'b0;
		end else if (clk_en) begin
			if (meas_end) begin
				data_ready <= 1'b1; // RQ9
			end else if (data_read) begin
				data_ready <= 1'b0;
			end
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_addr_low;
		clk_en && !addr_s2 |=> slave_addr == 7'h70;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("strap low address wrong"); // RQ1
	property p_addr_high;
		clk_en && addr_s2 |=> slave_addr == 7'h56;
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("strap high address wrong"); // RQ1
	property p_three_wire;
		clk_en && spi_mode && three_wire_select |=> three_wire_active && !four_wire_active;
	endproperty
	a_three_wire: assert property (p_three_wire) else $error("three-wire not chosen"); // RQ2
	property p_four_wire;
		clk_en && spi_mode && !three_wire_select |=> four_wire_active && !three_wire_active;
	endproperty
	a_four_wire: assert property (p_four_wire) else $error("four-wire not chosen"); // RQ2
	property p_i2c_hold;
		clk_en && !spi_mode && cs_s2 |=> !spi_mode && i2c_mode;
	endproperty
	a_i2c_hold: assert property (p_i2c_hold) else $error("left i2c with select high"); // RQ3
	property p_spi_enter;
		clk_en && !cs_s2 |=> spi_mode && !i2c_mode;
	endproperty
	a_spi_enter: assert property (p_spi_enter) else $error("low select did not enter spi"); // RQ4
	property p_spi_sticky;
		spi_mode |=> spi_mode [*2];
	endproperty
	a_spi_sticky: assert property (p_spi_sticky) else $error("spi mode dropped"); // RQ5
	property p_reset_i2c;
		$rose(rst_n) |-> !spi_mode && i2c_mode;
	endproperty
	a_reset_i2c: assert property (p_reset_i2c) else $error("reset not in i2c"); // RQ6
	property p_mode_write;
		clk_en && power_mode_wr |=> power_mode == $past(power_mode_req);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RQ7
	property p_sleep_quiet;
		clk_en && power_mode == PMODE_SLEEP && state == ST_IDLE |=> !adc_start;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("measurement in sleep"); // RQ8
	property p_forced_end;
		clk_en && meas_end && forced_now && !power_mode_wr
			|=> power_mode == PMODE_SLEEP && data_ready && state == ST_IDLE;
	endproperty
	a_forced_end: assert property (p_forced_end) else $error("forced did not return"); // RQ9
	property p_normal_standby;
		clk_en && meas_end && power_mode == PMODE_NORMAL |=> state == ST_STANDBY ##1 timer_busy;
	endproperty
	a_normal_standby: assert property (p_normal_standby) else $error("no standby"); // RQ10
	property p_capture;
		clk_en && meas_end |=> temp_raw_regs == $past(adc_temp)
			&& pressure_raw_regs == $past(adc_press);
	endproperty
	a_capture: assert property (p_capture) else $error("raw data not stored"); // RQ13

	c_forced: cover property (state == ST_MEASURE && forced_now ##[1:200] power_mode == PMODE_SLEEP);
	c_normal: cover property (state == ST_STANDBY ##[1:1000] state == ST_MEASURE);
	c_spi:    cover property (!spi_mode ##1 spi_mode);
	c_read:   cover property (data_ready ##1 !data_ready);

endmodule : pressure_sensor_mode_and_comp

/* File: sensor_defs.svh */
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH

// ==========================================================
// i2c slave addresses selected by the address strap
// ==========================================================
`define ADDR_STRAP_LOW_SLAVE    7'h70
`define ADDR_STRAP_HIGH_SLAVE   7'h56
`define SLAVE_ADDR_WIDTH        7

// ==========================================================
// raw measurement layout
// ==========================================================
`define RAW_WIDTH               24
`define RAW_BYTES               3
`define BYTE_WIDTH              8

// ==========================================================
// timing
// ==========================================================
`define SYS_CLK_PERIOD_NS       5
`define STANDBY_UNIT_NS         1000000
`define STANDBY_UNIT_CYCLES     (`STANDBY_UNIT_NS / `SYS_CLK_PERIOD_NS)
`define STANDBY_SEL_WIDTH       3
`define TIMER_WIDTH             32

// ==========================================================
// reset values
// ==========================================================
`define RESET_SPI_MODE          1'b0
`define RESET_RAW_BYTE          8'h00

`endif

/* File: sensor_pkg.sv */
package sensor_pkg;

	// ==========================================================
	// power mode field of the measurement control register
	// ==========================================================
	typedef enum logic [1:0] {
		PMODE_SLEEP      = 2'h0,
		PMODE_FORCED     = 2'h1,
		PMODE_FORCED_ALT = 2'h2,
		PMODE_NORMAL     = 2'h3
	} power_mode_t;

	// ==========================================================
	// measurement sequencer states, one-hot
	// ==========================================================
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h1,
		ST_MEASURE = 3'h2,
		ST_STANDBY = 3'h4
	} meas_state_t;

endpackage : sensor_pkg

/* File: test_pressure_sensor_mode_and_comp.sv */
`timescale 1ns/1ps
`include "sensor_defs.svh"

module test_pressure_sensor_mode_and_comp;
	import sensor_pkg::*;
	// =====
	// signals
	// =====
	logic                sys_clk, rst_n, clk_en, mode_strap_chip_select, addr_strap;
	logic                link_clk, three_wire_select, power_mode_wr, adc_done, data_read;
	power_mode_t         power_mode_req, power_mode;
	logic [2:0]          standby_sel;
	logic [23:0]         adc_temp, adc_press, temp_in, press_in, temp_raw_regs;
	logic [23:0]         pressure_raw_regs;
	logic [6:0]          slave_addr;
	logic                spi_mode, i2c_mode, three_wire_active, four_wire_active;
	logic                measuring, adc_start, data_ready, link_clk_rise;
	logic [3:0]          delay;
	logic [31:0]         seed, n_before;
	logic [31:0]         cyc = 32'h0, n_start = 32'h0, prev_st = 32'h0;
	logic [31:0]         last_st = 32'h0, n_rise = 32'h0;
	int                  n_fail, checked;
	logic                tw;
	// host copies of the stored coefficients
	real                 gain_coef [10];    // a1 a2 bt1 bt2 bp1 b11 bp2 b12 b21 bp3
	real                 temp_offset_coef;  // assembled from two bytes and an extension
	real                 press_offset_coef; // likewise
	localparam real      COEF_A = 0.0;      // per-coefficient offset, plain default
	localparam real      COEF_S = 1.0;      // per-coefficient span, plain default

	pressure_sensor_mode_and_comp #(.STANDBY_UNIT_CYCLES(4)) dut_u (
		.sys_clk                (sys_clk),
		.rst_n                  (rst_n),
		.clk_en                 (clk_en),
		.mode_strap_chip_select (mode_strap_chip_select),
		.addr_strap             (addr_strap),
		.link_clk               (link_clk),
		.three_wire_select      (three_wire_select),
		.power_mode_wr          (power_mode_wr),
		.power_mode_req         (power_mode_req),
		.standby_sel            (standby_sel),
		.adc_done               (adc_done),
		.adc_temp               (adc_temp),
		.adc_press              (adc_press),
		.data_read              (data_read),
		.spi_mode               (spi_mode),
		.i2c_mode               (i2c_mode),
		.slave_addr             (slave_addr),
		.three_wire_active      (three_wire_active),
		.four_wire_active       (four_wire_active),
		.power_mode             (power_mode),
		.measuring              (measuring),
		.adc_start              (adc_start),
		.temp_raw_regs          (temp_raw_regs),
		.pressure_raw_regs      (pressure_raw_regs),
		.data_ready             (data_ready),
		.link_clk_rise          (link_clk_rise)
	);
	adc_model adc_u (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.adc_start (adc_start),
		.delay     (delay),
		.temp_in   (temp_in),
		.press_in  (press_in),
		.adc_done  (adc_done),
		.adc_temp  (adc_temp),
		.adc_press (adc_press)
	);

	// clock at 200 MHz
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// cycle count, start pulses and link edges, plus hang guard
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (adc_start === 1'b1) begin
			n_start = n_start + 1;
			prev_st = last_st;
			last_st = cyc;
		end
		if (link_clk_rise === 1'b1)
			n_rise = n_rise + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction : xs

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_real(input real got, input real exp);
		checked++;
		if (got != exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, $realtobits(got), $realtobits(exp));
		end
	endtask : chk_real

	// host conversion of one stored word, read as two's complement
	function automatic real word_coef(input logic [15:0] w);
		return COEF_A + COEF_S * real'($signed(w)) / 32767.0;
	endfunction : word_coef

	// offset coefficient: two bytes above an extension nibble, sign kept
	function automatic real offset_coef(input logic [7:0] hi, input logic [7:0] lo,
		input logic [7:0] ext);
		logic signed [19:0] v;
		v = {hi, lo, ext[3:0]};
		return real'(v) / 16.0;
	endfunction : offset_coef

	// host temperature polynomial over the raw reading
	function automatic real host_temp(input logic [23:0] raw_temp_value);
		real d;
		d = real'(raw_temp_value);
		return temp_offset_coef + gain_coef[0] * d + gain_coef[1] * d * d;
	endfunction : host_temp

	// host pressure polynomial over raw pressure and temperature result
	function automatic real host_press(input logic [23:0] raw_press_value, input real temp_result);
		real d;
		real t;
		d = real'(raw_press_value);
		t = temp_result;
		return press_offset_coef + gain_coef[2] * t + gain_coef[4] * d
			+ gain_coef[5] * d * t + gain_coef[3] * t * t + gain_coef[6] * d * d
			+ gain_coef[7] * d * t * t + gain_coef[8] * d * d * t
			+ gain_coef[9] * d * d * d;
	endfunction : host_press

	task automatic give_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	// one-cycle mode write with fresh random converter data
	task automatic write_mode(input power_mode_t m);
		seed = xs(seed);
		temp_in = seed[23:0];
		seed = xs(seed);
		press_in = seed[23:0];
		delay = seed[31:28] & 4'h7;
		@(posedge sys_clk);
		power_mode_req <= m;
		power_mode_wr  <= 1'b1;
		@(posedge sys_clk);
		power_mode_wr  <= 1'b0;
	endtask : write_mode

	// bounded wait for a stored result, then consume it
	task automatic take_result();
		int i;
		real t_reg;
		real t_exp;
		for (i = 0; i < 100 && data_ready !== 1'b1; i++)
			tick(1);
		chk(temp_raw_regs, temp_in);
		chk(pressure_raw_regs, press_in);
		t_reg = host_temp(temp_raw_regs);
		t_exp = host_temp(temp_in);
		chk_real(t_reg / 256.0, t_exp / 256.0);
		chk_real(host_press(pressure_raw_regs, t_reg), host_press(press_in, t_exp));
		@(posedge sys_clk);
		data_read <= 1'b1;
		@(posedge sys_clk);
		data_read <= 1'b0;
		tick(1);
		chk(data_ready, 1'b0);
	endtask : take_result

	// frame of link clock at 48 ns, still between frames
	task automatic link_frame(input int n);
		repeat (n) begin
			#24 link_clk = 1'b1;
			#24 link_clk = 1'b0;
		end
	endtask : link_frame

	// =====
	// main sequence
	// =====
	initial begin
		{rst_n, mode_strap_chip_select, clk_en} = 3'b011;
		{addr_strap, link_clk, three_wire_select, power_mode_wr, data_read} = 5'h00;
		power_mode_req = PMODE_SLEEP;
		standby_sel = 3'h0;
		{temp_in, press_in, delay} = '0;
		seed = 32'h02E3;
		// host reads the stored coefficients once after power-up
		for (int j = 0; j < 10; j++) begin
			seed = xs(seed);
			gain_coef[j] = word_coef(seed[15:0]);
		end
		seed = xs(seed);
		temp_offset_coef = offset_coef(seed[23:16], seed[15:8], seed[7:0]);
		seed = xs(seed);
		press_offset_coef = offset_coef(seed[23:16], seed[15:8], seed[7:0]);
		tick(4);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		tick(1);
		chk(i2c_mode, 1'b1);
		chk(spi_mode, 1'b0);
		chk(slave_addr, 7'h70);
		chk(power_mode, PMODE_SLEEP);
		@(posedge sys_clk);
		addr_strap <= 1'b1;
		tick(4);
		chk(slave_addr, 7'h56);
		@(posedge sys_clk);
		addr_strap <= 1'b0;
		tick(4);
		chk(slave_addr, 7'h70);
		// sleep must stay quiet
		tick(30);
		chk(n_start, 32'h0);
		// both forced encodings, back to sleep alone
		for (int k = 1; k <= 2; k++) begin
			write_mode(power_mode_t'(k));
			tick(2);
			chk(measuring, 1'b1);
			take_result();
			chk(measuring, 1'b0);
			chk(power_mode, PMODE_SLEEP);
			chk(n_start, 32'(k));
			tick(20);
			chk(n_start, 32'(k));
		end
		// normal mode repeats with a standby gap
		seed = xs(seed);
		@(posedge sys_clk);
		standby_sel <= seed[2:0] % 3'h3;
		write_mode(PMODE_NORMAL);
		take_result();
		tick(120);
		chk(power_mode, PMODE_NORMAL);
		chk((last_st - prev_st) >= (32'h4 << standby_sel), 1'b1);
		chk((last_st - prev_st) <= (32'h4 << standby_sel) + delay + 8, 1'b1);
		write_mode(PMODE_SLEEP);
		tick(60);
		n_before = n_start;
		tick(60);
		chk(n_start, n_before);
		// link clock rising edges seen once each
		link_frame(4);
		tick(5);
		chk(n_rise, 32'h4);
		// strap low selects spi and sticks
		seed = xs(seed);
		tw = seed[0];
		@(posedge sys_clk);
		three_wire_select <= tw;
		mode_strap_chip_select <= 1'b0;
		tick(6);
		chk(spi_mode, 1'b1);
		chk(three_wire_active, tw);
		chk(four_wire_active, !tw);
		@(posedge sys_clk);
		three_wire_select <= !tw;
		mode_strap_chip_select <= 1'b1;
		tick(6);
		chk(spi_mode, 1'b1);
		chk(i2c_mode, 1'b0);
		chk(three_wire_active, !tw);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		tick(2);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		tick(1);
		chk(i2c_mode, 1'b1);
		chk(spi_mode, 1'b0);
		give_verdict();
	end
endmodule : test_pressure_sensor_mode_and_comp
